// *** hw/adc_pkg.sv ***
// Shared constants, state type and decode functions of the converter
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - RC clock selected: delay one instruction cycle before conversion clock.
// - Software picks reference: supply rails or external reference pins.
// - Conversion continues in sleep; software must pick the RC clock.
// - Result comes from successive approximation on the held sample.
// - Any reset restores control registers, powers off, aborts conversion.
// - On completion load result pair, set complete flag; clear go unless software sets it that cycle.
// - Power-on reset leaves the result pair uninitialised.
// - Non-zero acquisition code: sample programmed periods, then convert.
// - Acquisition code zero: go stops sampling and converts at once.
// - Acquisition field resets to manual, zero automatic time.
// - After each conversion the selected channel is sampled again.
// - No status separates acquisition end from conversion; go stays set.
// - Acquisition codes give 0,2,4,6,8,12,16,20 conversion periods.
// - Clock codes give 2,4,8,16,32,64 oscillator periods, x11 RC.
// - A conversion takes eleven conversion clock periods.
// - Clearing go mid-conversion aborts; result pair unchanged.
//////////////////////////////////////////////////////////////////////////////
package adc_pkg;

    // Timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int INSTR_CYCLE_NS = 160;
    localparam int RC_TAD_NS      = 1200;
    localparam logic [2:0] INSTR_CYCLES =
        3'((INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [6:0] RC_TAD_CYCLES = 7'(RC_TAD_NS / CLK_PERIOD_NS);
    localparam logic [4:0] CONV_TADS = 5'h0b;
    localparam logic [4:0] WAIT_TADS = 5'h02;

    // Register addresses
    localparam logic [2:0] ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] ADDR_CTRL2 = 3'h2;
    localparam logic [2:0] ADDR_RES_H = 3'h3;
    localparam logic [2:0] ADDR_RES_L = 3'h4;
    localparam logic [2:0] ADDR_IRQ   = 3'h5;

    // Field positions
    localparam int CTRL0_POWER_BIT = 0;
    localparam int CTRL0_GO_BIT    = 1;
    localparam int CTRL0_CHAN_LSB  = 2;
    localparam int CTRL1_VPOS_BIT  = 4;
    localparam int CTRL1_VNEG_BIT  = 5;
    localparam int CTRL1_CFG_LSB   = 0;
    localparam int CTRL2_FMT_BIT   = 7;
    localparam int CTRL2_ACQ_LSB   = 3;
    localparam int CTRL2_CLK_LSB   = 0;
    localparam int IRQ_FLAG_BIT    = 0;
    localparam int IRQ_EN_BIT      = 1;
    localparam int IRQ_GIE_BIT     = 2;

    // Reset values and writable masks
    localparam logic [7:0] CTRL1_RST  = 8'h00;
    localparam logic [7:0] CTRL2_RST  = 8'h00;
    localparam logic [7:0] CTRL1_MASK = 8'h3f;
    localparam logic [7:0] CTRL2_MASK = 8'hbf;
    localparam logic [9:0] SAR_MSB    = 10'h200;

    typedef enum logic [1:0] {
        ST_SAMPLE = 2'b00,
        ST_ACQ    = 2'b01,
        ST_CONV   = 2'b10,
        ST_WAIT   = 2'b11
    } seq_state_t;

    // Acquisition periods per code
    function automatic logic [4:0] acq_tads(input logic [2:0] sel);
        case (sel)
            3'h0:    acq_tads = 5'h00;
            3'h1:    acq_tads = 5'h02;
            3'h2:    acq_tads = 5'h04;
            3'h3:    acq_tads = 5'h06;
            3'h4:    acq_tads = 5'h08;
            3'h5:    acq_tads = 5'h0c;
            3'h6:    acq_tads = 5'h10;
            default: acq_tads = 5'h14;
        endcase
    endfunction

    // Oscillator periods per conversion clock code
    function automatic logic [6:0] tad_div(input logic [2:0] sel);
        case (sel)
            3'h0:    tad_div = 7'h02;
            3'h4:    tad_div = 7'h04;
            3'h1:    tad_div = 7'h08;
            3'h5:    tad_div = 7'h10;
            3'h2:    tad_div = 7'h20;
            3'h6:    tad_div = 7'h40;
            default: tad_div = RC_TAD_CYCLES;
        endcase
    endfunction

    function automatic logic is_rc(input logic [2:0] sel);
        is_rc = (sel[1:0] == 2'h3);
    endfunction

endpackage

// *** hw/conv_clk_if.sv ***
// Link between the sequencer and its conversion clock generator
`timescale 1ns/1ns
`default_nettype none
interface conv_clk_if;
    logic       run;
    logic [2:0] clk_sel;
    logic       sleep;
    logic       tad_tick;
    modport gen  (input run, clk_sel, sleep, output tad_tick);
    modport user (output run, clk_sel, sleep, input tad_tick);
endinterface
`default_nettype wire

// *** hw/tad_clock_gen.sv ***
// Conversion clock enable generator: divided oscillator or RC period
`timescale 1ns/1ns
`default_nettype none
module tad_clock_gen (
    input  wire logic   sys_clk_i,
    input  wire logic   rst_n_i,
    conv_clk_if.gen     clk_if
);

    logic [6:0] cnt_reg;
    logic [2:0] dly_reg;
    logic       tick_reg;
    logic       rc_w;
    logic [6:0] limit_w;

    // RC period is counted on the system clock; it keeps running in sleep
    assign rc_w    = adc_pkg::is_rc(clk_if.clk_sel);
    assign limit_w = adc_pkg::tad_div(clk_if.clk_sel);
    assign clk_if.tad_tick = tick_reg;

    // Idle restarts the divider so every sequence begins on a full period
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= 7'h00;
            dly_reg  <= adc_pkg::INSTR_CYCLES;
            tick_reg <= 1'b0;
        end else if (!clk_if.run) begin
            cnt_reg  <= 7'h00;
            dly_reg  <= adc_pkg::INSTR_CYCLES;
            tick_reg <= 1'b0;
        end else if (rc_w && dly_reg != 3'h0) begin
            dly_reg  <= dly_reg - 3'h1;
            tick_reg <= 1'b0;
        end else if (!rc_w && clk_if.sleep) begin
            tick_reg <= 1'b0;
        end else if (cnt_reg == limit_w - 7'h01) begin
            cnt_reg  <= 7'h00;
            tick_reg <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + 7'h01;
            tick_reg <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_rc_start;
        $rose(clk_if.run) && rc_w;
    endsequence

    AST_RC_START_DELAY: assert property (
        s_rc_start |-> (cnt_reg == 7'h00 && !clk_if.tad_tick)[*5]
            ##1 (!clk_if.tad_tick)[*4])
        else $error("RC clock started before the start delay");

    AST_DIV2_TICK: assert property (
        ($rose(clk_if.run) && clk_if.clk_sel == 3'h0 && !clk_if.sleep)
        ##1 (clk_if.run && !clk_if.sleep && $stable(clk_if.clk_sel))
        |-> ##1 clk_if.tad_tick)
        else $error("Divide by two tick missing");

    AST_SLEEP_STOPS: assert property (
        (clk_if.sleep && !rc_w) |=> !clk_if.tad_tick)
        else $error("Oscillator tick in sleep");

endmodule
`default_nettype wire

// *** hw/sar_adc_sequencer.sv ***
// Converter control, register file and successive approximation sequencer
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       we_i,
    input  wire logic       re_i,
    output logic      [7:0] rdata_o,
    input  wire logic       sleep_i,
    input  wire logic       cmp_i,
    output logic            sample_en_o,
    output logic      [9:0] dac_code_o,
    output logic      [3:0] chan_sel_o,
    output logic            vref_pos_ext_o,
    output logic            vref_neg_ext_o,
    output logic      [3:0] port_cfg_o,
    output logic            conv_power_on_o,
    output logic            irq_req_o
);

    //////////////////////////////////////////////////////////////////////////
    // Registers and wires

    logic                power_reg, go_reg, go_next;
    logic [3:0]          chan_reg;
    logic [7:0]          ctrl1_reg, ctrl2_reg;
    logic [7:0]          result_high_reg, result_low_reg;
    logic                flag_reg, flag_next, irq_en_reg, gie_reg;
    logic [7:0]          rdata_reg, rd_mux;
    adc_pkg::seq_state_t state_reg, state_next;
    logic [4:0]          tad_cnt_reg;
    logic [9:0]          sar_reg, mask_reg, sar_eval;
    logic                cmp_s1_reg, cmp_s2_reg, cmp_s3_reg, cmp_val_reg;

    logic       wr_ctrl0, wr_ctrl1, wr_ctrl2, wr_high, wr_low, wr_irq;
    logic       tick, start_ok, done, fmt_right;
    logic [2:0] acq_sel;
    logic [4:0] acq_len;
    logic [7:0] res_high_w, res_low_w;

    conv_clk_if clk_if ();

    tad_clock_gen u_tad_gen (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_if    (clk_if)
    );

    //////////////////////////////////////////////////////////////////////////
    // Decode

    // Write strobes per register
    assign wr_ctrl0 = we_i && (addr_i == adc_pkg::ADDR_CTRL0);
    assign wr_ctrl1 = we_i && (addr_i == adc_pkg::ADDR_CTRL1);
    assign wr_ctrl2 = we_i && (addr_i == adc_pkg::ADDR_CTRL2);
    assign wr_high  = we_i && (addr_i == adc_pkg::ADDR_RES_H);
    assign wr_low   = we_i && (addr_i == adc_pkg::ADDR_RES_L);
    assign wr_irq   = we_i && (addr_i == adc_pkg::ADDR_IRQ);

    // Sequencing terms
    assign tick      = clk_if.tad_tick;
    assign acq_sel   = ctrl2_reg[adc_pkg::CTRL2_ACQ_LSB +: 3];
    assign acq_len   = adc_pkg::acq_tads(acq_sel);
    assign fmt_right = ctrl2_reg[adc_pkg::CTRL2_FMT_BIT];
    assign start_ok  = power_reg && go_reg
                    && (state_reg == adc_pkg::ST_SAMPLE);
    assign done      = power_reg && go_reg && tick
                    && (state_reg == adc_pkg::ST_CONV)
                    && (tad_cnt_reg == adc_pkg::CONV_TADS - 5'h01);

    // Trial bit kept when the held input is at or above the DAC level
    // Comparator lags the DAC by up to four cycles: short periods outrun it
    assign sar_eval = (cmp_val_reg ? sar_reg : (sar_reg & ~mask_reg))
                    | (mask_reg >> 1);

    // Result pair in the selected justification
    assign res_high_w = fmt_right ? {6'h00, sar_eval[9:8]} : sar_eval[9:2];
    assign res_low_w  = fmt_right ? sar_eval[7:0] : {sar_eval[1:0], 6'h00};

    // Outputs; sampling stops as soon as conversion begins
    assign sample_en_o = power_reg
        && (state_reg == adc_pkg::ST_SAMPLE
            || state_reg == adc_pkg::ST_ACQ);
    assign dac_code_o      = sar_reg;
    assign chan_sel_o      = chan_reg;
    assign vref_pos_ext_o  = ctrl1_reg[adc_pkg::CTRL1_VPOS_BIT];
    assign vref_neg_ext_o  = ctrl1_reg[adc_pkg::CTRL1_VNEG_BIT];
    assign port_cfg_o      = ctrl1_reg[adc_pkg::CTRL1_CFG_LSB +: 4];
    assign conv_power_on_o = power_reg;
    assign irq_req_o       = flag_reg && irq_en_reg && gie_reg;
    assign rdata_o         = rdata_reg;

    // Clock generator runs for the whole sequence, not per phase
    assign clk_if.run     = power_reg && (state_reg != adc_pkg::ST_SAMPLE);
    assign clk_if.clk_sel = ctrl2_reg[adc_pkg::CTRL2_CLK_LSB +: 3];
    assign clk_if.sleep   = sleep_i;

    //////////////////////////////////////////////////////////////////////////
    // Comparator synchroniser: analog edge counts once stages two and three
    // agree, which also filters a single metastable sample
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_s1_reg  <= 1'b0;
            cmp_s2_reg  <= 1'b0;
            cmp_s3_reg  <= 1'b0;
            cmp_val_reg <= 1'b0;
        end else begin
            cmp_s1_reg <= cmp_i;
            cmp_s2_reg <= cmp_s1_reg;
            cmp_s3_reg <= cmp_s2_reg;
            if (cmp_s2_reg == cmp_s3_reg) begin
                cmp_val_reg <= cmp_s3_reg;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sequencer state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            adc_pkg::ST_SAMPLE: begin
                if (start_ok) begin
                    state_next = (acq_len == 5'h00) ? adc_pkg::ST_CONV
                                                    : adc_pkg::ST_ACQ;
                end
            end
            adc_pkg::ST_ACQ: begin
                if (!go_reg) begin
                    state_next = adc_pkg::ST_WAIT;
                end else if (tick && tad_cnt_reg == acq_len - 5'h01) begin
                    state_next = adc_pkg::ST_CONV;
                end
            end
            adc_pkg::ST_CONV: begin
                if (!go_reg || done) begin
                    state_next = adc_pkg::ST_WAIT;
                end
            end
            adc_pkg::ST_WAIT: begin
                if (tick && tad_cnt_reg == adc_pkg::WAIT_TADS - 5'h01) begin
                    state_next = adc_pkg::ST_SAMPLE;
                end
            end
            default: state_next = adc_pkg::ST_SAMPLE;
        endcase
        if (!power_reg) begin
            state_next = adc_pkg::ST_SAMPLE;
        end
    end

    // State and period counter; the counter restarts at each phase change
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg   <= adc_pkg::ST_SAMPLE;
            tad_cnt_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                tad_cnt_reg <= 5'h00;
            end else if (tick) begin
                tad_cnt_reg <= tad_cnt_reg + 5'h01;
            end
        end
    end

    // Successive approximation: first period holds, then one bit per period
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sar_reg  <= 10'h000;
            mask_reg <= 10'h000;
        end else if (state_next == adc_pkg::ST_CONV
                     && state_reg != adc_pkg::ST_CONV) begin
            sar_reg  <= adc_pkg::SAR_MSB;
            mask_reg <= adc_pkg::SAR_MSB;
        end else if (state_reg == adc_pkg::ST_CONV && tick
                     && tad_cnt_reg != 5'h00) begin
            sar_reg  <= sar_eval;
            mask_reg <= mask_reg >> 1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Control registers

    // Go is accepted only while already powered; a software set wins
    // over the hardware clear at completion
    always_comb begin
        go_next = go_reg;
        if (wr_ctrl0) begin
            go_next = wdata_i[adc_pkg::CTRL0_GO_BIT]
                   && wdata_i[adc_pkg::CTRL0_POWER_BIT] && power_reg;
        end else if (done || !power_reg) begin
            go_next = 1'b0;
        end
    end

    // Completion sets the flag even against a clearing write
    always_comb begin
        flag_next = flag_reg;
        if (done) begin
            flag_next = 1'b1;
        end else if (wr_irq) begin
            flag_next = wdata_i[adc_pkg::IRQ_FLAG_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_reg  <= 1'b0;
            go_reg     <= 1'b0;
            chan_reg   <= 4'h0;
            ctrl1_reg  <= adc_pkg::CTRL1_RST;
            ctrl2_reg  <= adc_pkg::CTRL2_RST;
            flag_reg   <= 1'b0;
            irq_en_reg <= 1'b0;
            gie_reg    <= 1'b0;
        end else begin
            go_reg   <= go_next;
            flag_reg <= flag_next;
            if (wr_ctrl0) begin
                power_reg <= wdata_i[adc_pkg::CTRL0_POWER_BIT];
                chan_reg  <= wdata_i[adc_pkg::CTRL0_CHAN_LSB +: 4];
            end
            if (wr_ctrl1) begin
                ctrl1_reg <= wdata_i & adc_pkg::CTRL1_MASK;
            end
            if (wr_ctrl2) begin
                ctrl2_reg <= wdata_i & adc_pkg::CTRL2_MASK;
            end
            if (wr_irq) begin
                irq_en_reg <= wdata_i[adc_pkg::IRQ_EN_BIT];
                gie_reg    <= wdata_i[adc_pkg::IRQ_GIE_BIT];
            end
        end
    end

    // Result pair has no reset on purpose; completion beats a write
    always_ff @(posedge sys_clk_i) begin
        if (done) begin
            result_high_reg <= res_high_w;
            result_low_reg  <= res_low_w;
        end else begin
            if (wr_high) begin
                result_high_reg <= wdata_i;
            end
            if (wr_low) begin
                result_low_reg <= wdata_i;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read port: data valid only in the cycle after the strobe
    always_comb begin
        case (addr_i)
            adc_pkg::ADDR_CTRL0: rd_mux = {2'h0, chan_reg, go_reg, power_reg};
            adc_pkg::ADDR_CTRL1: rd_mux = ctrl1_reg;
            adc_pkg::ADDR_CTRL2: rd_mux = ctrl2_reg;
            adc_pkg::ADDR_RES_H: rd_mux = result_high_reg;
            adc_pkg::ADDR_RES_L: rd_mux = result_low_reg;
            adc_pkg::ADDR_IRQ:   rd_mux = {5'h00, gie_reg, irq_en_reg,
                                           flag_reg};
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= re_i ? rd_mux : 8'h00;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_acq_to_conv;
        (state_reg == adc_pkg::ST_ACQ) ##1 (state_reg == adc_pkg::ST_CONV);
    endsequence

    sequence s_last_period;
        state_reg == adc_pkg::ST_CONV && tick && go_reg && power_reg
        && tad_cnt_reg == 5'h0a && !wr_ctrl0 && !wr_irq;
    endsequence

    AST_OFF_NO_START: assert property (
        !power_reg |=> (state_reg == adc_pkg::ST_SAMPLE && !go_reg))
        else $error("Sequence running while powered off");
    AST_MANUAL_GO: assert property (
        (start_ok && acq_sel == 3'h0)
        |=> (state_reg == adc_pkg::ST_CONV && !sample_en_o))
        else $error("Manual go did not convert at once");
    AST_AUTO_ACQ: assert property (
        (start_ok && acq_sel != 3'h0)
        |=> (state_reg == adc_pkg::ST_ACQ && sample_en_o))
        else $error("Programmed go did not keep sampling");
    AST_ACQ_TWENTY: assert property (
        (state_reg == adc_pkg::ST_ACQ && acq_sel == 3'h7 && tick
         && tad_cnt_reg == 5'h13 && go_reg && power_reg)
        |=> state_reg == adc_pkg::ST_CONV)
        else $error("Code seven did not give twenty periods");
    AST_GO_THROUGH: assert property (
        s_acq_to_conv |-> go_reg)
        else $error("Go dropped between acquisition and conversion");
    AST_DONE: assert property (
        s_last_period |=> (!go_reg && flag_reg
            && state_reg == adc_pkg::ST_WAIT
            && result_low_reg == $past(res_low_w)))
        else $error("Completion effects missing");
    AST_ABORT: assert property (
        (state_reg == adc_pkg::ST_CONV && !go_reg && power_reg && !wr_irq)
        |=> (state_reg == adc_pkg::ST_WAIT && $stable(flag_reg)))
        else $error("Abort not handled");
    AST_MSB_TRIAL: assert property (
        (state_reg == adc_pkg::ST_CONV && tick && tad_cnt_reg == 5'h01
         && go_reg && power_reg)
        |=> (dac_code_o[9] == $past(cmp_val_reg) && dac_code_o[8]))
        else $error("Most significant trial wrong");
    AST_RESUME: assert property (
        (state_reg == adc_pkg::ST_WAIT && tick && tad_cnt_reg == 5'h01
         && power_reg) |=> sample_en_o)
        else $error("Sampling not resumed");
    AST_FLAG_STICKY: assert property (
        (flag_reg && !wr_irq) |=> flag_reg)
        else $error("Complete flag cleared without software");

endmodule
`default_nettype wire

// *** tb/analog_model.sv ***
// Behavioural analog front end: sample-and-hold and comparator
`timescale 1ns/1ns
`default_nettype none
module analog_model (
    input  wire logic       sample_en_i,
    input  wire logic [9:0] vin_i,
    input  wire logic [9:0] dac_code_i,
    output logic            cmp_o
);
    logic [9:0] held;
    // Track while the switch is closed; hold once the converter opens it
    always_latch begin
        if (sample_en_i) held <= vin_i;
    end
    assign cmp_o = (held >= dac_code_i);
endmodule
`default_nettype wire

// *** tb/sar_adc_sequencer_tb.sv ***
// Self-checking bench of the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer_tb;
    logic       clk = 0, rst_n = 0, we = 0, re = 0, slp = 0;
    logic       cmp, smp, pwr, irq, f;
    logic       vp, vn;
    logic [3:0] ch, pc;
    logic [2:0] addr = 0;
    logic [7:0] wdata = 0, rdata, rd_v, exp_h, exp_l;
    logic [9:0] dac, v, vin = 0;
    int         n_fail = 0, total_checks = 0, cyc = 0, tad, lat, lim;
    //////////////////////////////////////////////////////////////////////
    sar_adc_sequencer dut (.sys_clk_i(clk), .rst_n_i(rst_n),
        .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
        .rdata_o(rdata), .sleep_i(slp), .cmp_i(cmp), .sample_en_o(smp),
        .dac_code_o(dac), .chan_sel_o(ch), .vref_pos_ext_o(vp),
        .vref_neg_ext_o(vn), .port_cfg_o(pc), .conv_power_on_o(pwr),
        .irq_req_o(irq));
    analog_model far (.sample_en_i(smp), .vin_i(vin), .dac_code_i(dac),
        .cmp_o(cmp));
    // Clock and hang guard; a stuck poll still reaches the verdict
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            test_done;
        end
    end
    //////////////////////////////////////////////////////////////////////
    // Bus cycles, comparison and verdict
    task automatic check(input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; we <= 1;
        @(posedge clk);
        we <= 0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a; re <= 1;
        @(posedge clk);
        re <= 0;
        @(negedge clk);
        rd_v = rdata;
    endtask
    function automatic int acq_n(input int c);
        int t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
        return t[c];
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////
    // Main sequence: every acquisition code, last one on RC in sleep
    initial begin
        void'($urandom(20474));
        repeat (10) @(posedge clk);
        rst_n <= 1;
        for (int a = 0; a < 8; a++) begin
            if (a != 3 && a != 4) begin
                rd(3'(a));
                check(rd_v, 0);
            end
        end
        $display("test reset_values done");
        exp_h = 8'($urandom);
        wr(3'h1, exp_h);
        rd(3'h1);
        check(rd_v, exp_h & 8'h3f);
        check({vn, vp, pc}, exp_h[5:0]);
        wr(3'h5, 8'h06);
        for (int i = 0; i < 8; i++) begin
            v = 10'($urandom);
            f = 1'($urandom);
            tad = (i == 7) ? 30 : 8;
            slp <= (i == 7);
            vin <= v;
            exp_h = f ? {6'h0, v[9:8]} : v[9:2];
            exp_l = f ? v[7:0] : {v[1:0], 6'h0};
            wr(3'h2, {f, 1'b0, 3'(i), (i == 7) ? 3'h7 : 3'h1});
            wr(3'h0, 8'h01 | 8'(i << 2));
            repeat (3 * tad) @(posedge clk);
            wr(3'h0, 8'h03 | 8'(i << 2));
            repeat (4) @(posedge clk);
            @(negedge clk);
            check(smp, i != 0);
            check(ch, 4'(i));
            lat = 6;
            do begin
                rd(3'h0);
                lat += 2;
            end while (rd_v[1] && lat < 3000);
            lim = (acq_n(i) + 11) * tad;
            check(lat >= lim && lat <= lim + 2 * tad + 16, 1);
            check(irq, 1);
            rd(3'h3);
            check(rd_v, exp_h);
            rd(3'h4);
            check(rd_v, exp_l);
            wr(3'h5, 8'h06);
            rd(3'h5);
            check({rd_v, irq}, {8'h06, 1'b0});
            repeat (2 * tad + 4) @(posedge clk);
            check(smp, 1);
            $display("test conversion %0d done", i);
        end
        // Abort mid-conversion keeps the old result and flag
        slp <= 0;
        vin <= ~v;
        wr(3'h2, 8'h01);
        wr(3'h0, 8'h03);
        repeat (40) @(posedge clk);
        wr(3'h0, 8'h01);
        repeat (120) @(posedge clk);
        rd(3'h4);
        check(rd_v, exp_l);
        rd(3'h5);
        check(rd_v, 8'h06);
        // Go while powered off, then reset in mid-conversion
        wr(3'h0, 8'h00);
        wr(3'h0, 8'h02);
        rd(3'h0);
        check({rd_v, pwr}, 0);
        wr(3'h2, 8'h00);
        wr(3'h0, 8'h01);
        wr(3'h0, 8'h03);
        repeat (20) @(posedge clk);
        rst_n <= 0;
        @(posedge clk);
        check({pwr, dac}, 0);
        rst_n <= 1;
        rd(3'h0);
        check(rd_v, 0);
        $display("test abort_reset done");
        test_done;
    end
endmodule
`default_nettype wire
